/* File: src/pbdec_params.svh */
// Register offsets, field positions, reset values and decode ranges
`ifndef PBDEC_PARAMS_SVH
`define PBDEC_PARAMS_SVH
`define PBDEC_OFS_BRCTL 8'h00
`define PBDEC_OFS_CMD 8'h04
`define PBDEC_OFS_SSTAT 8'h08
`define PBDEC_OFS_IOWIN 8'h0c
`define PBDEC_OFS_MEMWIN 8'h10
`define PBDEC_OFS_STAT 8'h14
`define PBDEC_BC_MABORT_MODE 5
`define PBDEC_BC_RSVD 4
`define PBDEC_BC_LEGACY_VIDEO 3
`define PBDEC_BC_ALIAS 2
`define PBDEC_BC_ERR_FWD 1
`define PBDEC_BC_PAR_RESP 0
`define PBDEC_BC_RW_MASK 16'h002f
`define PBDEC_BC_RESET 16'h0000
`define PBDEC_CMD_IO 0
`define PBDEC_CMD_MEM 1
`define PBDEC_CMD_SYSERR 8
`define PBDEC_CMD_RW_MASK 16'h0103
`define PBDEC_CMD_RESET 16'h0000
`define PBDEC_SSTAT_PAR 8
`define PBDEC_SSTAT_RESET 16'h0000
`define PBDEC_WIN_RESET 32'h0000_0000
`define PBDEC_VID_MEM_LO 32'h000a_0000
`define PBDEC_VID_MEM_HI 32'h000b_ffff
`define PBDEC_VID_IO_A_LO 10'h3b0
`define PBDEC_VID_IO_A_HI 10'h3bb
`define PBDEC_VID_IO_B_LO 10'h3c0
`define PBDEC_VID_IO_B_HI 10'h3df
`define PBDEC_ALL_ONES 32'hffff_ffff
`endif

/* File: src/pbdec_pkg.sv */
// Types shared by the bridge decode and error control block
package pbdec_pkg;
   typedef enum logic [1:0] {
      APB_IDLE = 2'b00,
      APB_RESP = 2'b01
   } pbdec_apb_e;
   typedef logic [15:0] pbdec_reg16_t;
endpackage : pbdec_pkg

/* File: src/pbdec_sync.sv */
// Two-stage synchroniser for a level arriving from a pin
`timescale 1ns/100ps
module pbdec_sync
   import pbdec_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic async_in,
   output logic sync_out
);
   logic stage1;

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         stage1 <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule : pbdec_sync

/* File: src/pbdec_decode.sv */
// Address decode for downstream claims and upstream forwarding
`timescale 1ns/100ps
`include "pbdec_params.svh"
module pbdec_decode
   import pbdec_pkg::*;
(
   input wire logic legacy_video,
   input wire logic alias_filter,
   input wire logic io_space_enable,
   input wire logic memory_space_enable,
   input wire logic [15:0] io_base,
   input wire logic [15:0] io_limit,
   input wire logic [15:0] mem_base,
   input wire logic [15:0] mem_limit,
   input wire logic [31:0] pri_addr,
   input wire logic pri_io,
   input wire logic [31:0] sec_addr,
   input wire logic sec_io,
   output logic pri_hit,
   output logic sec_hit
);
   function automatic logic fn_vid_io(input logic [31:0] a);
      logic [9:0] low;
      low = a[9:0];
      return (a[31:16] == 16'h0000) &&
         (((low >= `PBDEC_VID_IO_A_LO) && (low <= `PBDEC_VID_IO_A_HI)) ||
          ((low >= `PBDEC_VID_IO_B_LO) && (low <= `PBDEC_VID_IO_B_HI)));
   endfunction : fn_vid_io

   function automatic logic fn_vid_mem(input logic [31:0] a);
      return (a >= `PBDEC_VID_MEM_LO) && (a <= `PBDEC_VID_MEM_HI);
   endfunction : fn_vid_mem

   // I/O window lives in the first 64 KB only
   function automatic logic fn_io_win(input logic [31:0] a,
                                      input logic [15:0] lo,
                                      input logic [15:0] hi);
      return (a[31:16] == 16'h0000) && (a[15:0] >= lo) && (a[15:0] <= hi);
   endfunction : fn_io_win

   function automatic logic fn_mem_win(input logic [31:0] a,
                                       input logic [15:0] lo,
                                       input logic [15:0] hi);
      return (a[31:16] >= lo) && (a[31:16] <= hi);
   endfunction : fn_mem_win

   // Upper 768 bytes of a 1 KB block: offset 100h and above
   function automatic logic fn_alias_top(input logic [31:0] a);
      return a[9:8] != 2'b00;
   endfunction : fn_alias_top

   always_comb begin
      logic p_vio;
      logic p_vmem;
      logic p_iow;
      logic s_vio;
      logic s_vmem;
      logic s_iow;
      p_vio = legacy_video && fn_vid_io(pri_addr);
      p_vmem = legacy_video && fn_vid_mem(pri_addr);
      s_vio = legacy_video && fn_vid_io(sec_addr);
      s_vmem = legacy_video && fn_vid_mem(sec_addr);
      p_iow = fn_io_win(pri_addr, io_base, io_limit);
      s_iow = fn_io_win(sec_addr, io_base, io_limit);
      if (pri_io) begin
         pri_hit = io_space_enable &&
            (p_vio || (p_iow && !(alias_filter && fn_alias_top(pri_addr))));
      end else begin
         pri_hit = memory_space_enable &&
            (p_vmem || fn_mem_win(pri_addr, mem_base, mem_limit));
      end
      if (sec_io) begin
         sec_hit = !s_vio &&
            (!s_iow || (alias_filter && fn_alias_top(sec_addr)));
      end else begin
         sec_hit = !s_vmem && !fn_mem_win(sec_addr, mem_base, mem_limit);
      end
   end
endmodule : pbdec_decode

/* File: src/pbdec_ctrl.sv */
// Bridge control: master abort, legacy decode, error forwarding, APB regs
`timescale 1ns/100ps
`include "pbdec_params.svh"
module pbdec_ctrl
   import pbdec_pkg::*;
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic ma_event,
   input wire logic ma_posted_done,
   input wire logic ma_read,
   output logic ma_target_abort,
   output logic ma_read_all_ones,
   output logic ma_write_discard,
   output logic [31:0] ma_read_data,
   input wire logic pri_req_valid,
   input wire logic [31:0] pri_req_addr,
   input wire logic pri_req_io,
   output logic pri_claim_valid,
   output logic pri_claim,
   input wire logic sec_req_valid,
   input wire logic [31:0] sec_req_addr,
   input wire logic sec_req_io,
   output logic sec_claim_valid,
   output logic sec_claim,
   input wire logic sec_parity_err,
   input wire logic sec_parity_as_master,
   input wire logic downstream_system_error_in,
   output logic upstream_system_error_out,
   output logic downstream_parity_error_out
);
   pbdec_apb_e apb_state;
   pbdec_apb_e next_apb_state;
   pbdec_reg16_t bridge_control;
   pbdec_reg16_t next_bridge_control;
   pbdec_reg16_t pri_command;
   pbdec_reg16_t next_pri_command;
   pbdec_reg16_t sec_status;
   pbdec_reg16_t next_sec_status;
   logic [31:0] io_window;
   logic [31:0] next_io_window;
   logic [31:0] mem_window;
   logic [31:0] next_mem_window;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic next_ma_target_abort;
   logic next_ma_read_all_ones;
   logic next_ma_write_discard;
   logic [31:0] next_ma_read_data;
   logic next_pri_claim_valid;
   logic next_pri_claim;
   logic next_sec_claim_valid;
   logic next_sec_claim;
   logic next_upstream_system_error_out;
   logic next_downstream_parity_error_out;
   logic serr_in_sync;
   logic pri_hit;
   logic sec_hit;
   logic apb_fire;
   logic wr_fire;
   logic master_abort_report_mode;
   logic legacy_video;
   logic legacy_io_alias_filter;
   logic secondary_error_forward_enable;
   logic secondary_parity_response_enable;
   logic io_space_enable;
   logic memory_space_enable;
   logic primary_syserr_enable;
   logic data_parity_detected_flag;

   function automatic logic fn_sel(input logic [7:0] a,
                                   input logic [7:0] ofs);
      return a == ofs;
   endfunction : fn_sel

   function automatic logic fn_mapped(input logic [7:0] a);
      return fn_sel(a, `PBDEC_OFS_BRCTL) || fn_sel(a, `PBDEC_OFS_CMD) ||
         fn_sel(a, `PBDEC_OFS_SSTAT) || fn_sel(a, `PBDEC_OFS_IOWIN) ||
         fn_sel(a, `PBDEC_OFS_MEMWIN) || fn_sel(a, `PBDEC_OFS_STAT);
   endfunction : fn_mapped

   assign master_abort_report_mode = bridge_control[`PBDEC_BC_MABORT_MODE];
   assign legacy_video = bridge_control[`PBDEC_BC_LEGACY_VIDEO];
   assign legacy_io_alias_filter = bridge_control[`PBDEC_BC_ALIAS];
   assign secondary_error_forward_enable = bridge_control[`PBDEC_BC_ERR_FWD];
   assign secondary_parity_response_enable =
      bridge_control[`PBDEC_BC_PAR_RESP];
   assign io_space_enable = pri_command[`PBDEC_CMD_IO];
   assign memory_space_enable = pri_command[`PBDEC_CMD_MEM];
   assign primary_syserr_enable = pri_command[`PBDEC_CMD_SYSERR];
   assign data_parity_detected_flag = sec_status[`PBDEC_SSTAT_PAR];

   // Error pin comes from the secondary bus, so it is synchronised first
   pbdec_sync u_serr_sync (
      .ref_clk(ref_clk),
      .sys_rst(sys_rst),
      .async_in(downstream_system_error_in),
      .sync_out(serr_in_sync)
   );

   pbdec_decode u_decode (
      .legacy_video(legacy_video),
      .alias_filter(legacy_io_alias_filter),
      .io_space_enable(io_space_enable),
      .memory_space_enable(memory_space_enable),
      .io_base(io_window[15:0]),
      .io_limit(io_window[31:16]),
      .mem_base(mem_window[15:0]),
      .mem_limit(mem_window[31:16]),
      .pri_addr(pri_req_addr),
      .pri_io(pri_req_io),
      .sec_addr(sec_req_addr),
      .sec_io(sec_req_io),
      .pri_hit(pri_hit),
      .sec_hit(sec_hit)
   );

   // One wait state so read data can leave a flip-flop
   assign apb_fire = psel && penable && pready;
   assign wr_fire = apb_fire && pwrite && fn_mapped(paddr);

   always_comb begin
      next_apb_state = APB_IDLE;
      next_pready = 1'b0;
      next_pslverr = 1'b0;
      next_prdata = prdata;
      case (apb_state)
         APB_IDLE: begin
            if (psel && penable) begin
               next_apb_state = APB_RESP;
               next_pready = 1'b1;
               next_pslverr = !fn_mapped(paddr);
               next_prdata = 32'h0000_0000;
               if (!pwrite) begin
                  if (fn_sel(paddr, `PBDEC_OFS_BRCTL)) begin
                     next_prdata = {16'h0000,
                        bridge_control & `PBDEC_BC_RW_MASK};
                  end
                  if (fn_sel(paddr, `PBDEC_OFS_CMD)) begin
                     next_prdata = {16'h0000, pri_command};
                  end
                  if (fn_sel(paddr, `PBDEC_OFS_SSTAT)) begin
                     next_prdata = {16'h0000, sec_status};
                  end
                  if (fn_sel(paddr, `PBDEC_OFS_IOWIN)) begin
                     next_prdata = io_window;
                  end
                  if (fn_sel(paddr, `PBDEC_OFS_MEMWIN)) begin
                     next_prdata = mem_window;
                  end
                  if (fn_sel(paddr, `PBDEC_OFS_STAT)) begin
                     next_prdata = {29'h0000_0000,
                        downstream_parity_error_out, serr_in_sync,
                        upstream_system_error_out};
                  end
               end
            end
         end
         APB_RESP: begin
            next_apb_state = APB_IDLE;
         end
         default: begin
            next_apb_state = APB_IDLE;
         end
      endcase
   end

   always_comb begin
      next_bridge_control = bridge_control;
      next_pri_command = pri_command;
      next_sec_status = sec_status;
      next_io_window = io_window;
      next_mem_window = mem_window;
      if (wr_fire && fn_sel(paddr, `PBDEC_OFS_BRCTL)) begin
         next_bridge_control = pwdata[15:0] & `PBDEC_BC_RW_MASK;
      end
      if (wr_fire && fn_sel(paddr, `PBDEC_OFS_CMD)) begin
         next_pri_command = pwdata[15:0] & `PBDEC_CMD_RW_MASK;
      end
      if (wr_fire && fn_sel(paddr, `PBDEC_OFS_IOWIN)) begin
         next_io_window = pwdata;
      end
      if (wr_fire && fn_sel(paddr, `PBDEC_OFS_MEMWIN)) begin
         next_mem_window = pwdata;
      end
      // Write one to clear; a same-cycle parity event wins
      if (wr_fire && fn_sel(paddr, `PBDEC_OFS_SSTAT) &&
          pwdata[`PBDEC_SSTAT_PAR]) begin
         next_sec_status[`PBDEC_SSTAT_PAR] = 1'b0;
      end
      if (sec_parity_err && secondary_parity_response_enable &&
          sec_parity_as_master) begin
         next_sec_status[`PBDEC_SSTAT_PAR] = 1'b1;
      end
   end

   always_comb begin
      logic ma_serr;
      logic fwd_serr;
      logic par_serr;
      ma_serr = ma_event && master_abort_report_mode && ma_posted_done &&
         primary_syserr_enable;
      next_ma_target_abort = ma_event && master_abort_report_mode &&
         !ma_posted_done;
      next_ma_read_all_ones = ma_event && !master_abort_report_mode &&
         ma_read;
      next_ma_write_discard = ma_event && !master_abort_report_mode &&
         !ma_read;
      next_ma_read_data = next_ma_read_all_ones ? `PBDEC_ALL_ONES :
         32'h0000_0000;
      fwd_serr = serr_in_sync && secondary_error_forward_enable &&
         primary_syserr_enable;
      par_serr = sec_parity_err && secondary_parity_response_enable &&
         primary_syserr_enable;
      next_upstream_system_error_out = ma_serr || fwd_serr || par_serr;
      next_downstream_parity_error_out = sec_parity_err &&
         secondary_parity_response_enable;
      next_pri_claim_valid = pri_req_valid;
      next_pri_claim = pri_req_valid && pri_hit;
      next_sec_claim_valid = sec_req_valid;
      next_sec_claim = sec_req_valid && sec_hit;
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         apb_state <= APB_IDLE;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         bridge_control <= `PBDEC_BC_RESET;
         pri_command <= `PBDEC_CMD_RESET;
         sec_status <= `PBDEC_SSTAT_RESET;
         io_window <= `PBDEC_WIN_RESET;
         mem_window <= `PBDEC_WIN_RESET;
         ma_target_abort <= 1'b0;
         ma_read_all_ones <= 1'b0;
         ma_write_discard <= 1'b0;
         ma_read_data <= 32'h0000_0000;
         pri_claim_valid <= 1'b0;
         pri_claim <= 1'b0;
         sec_claim_valid <= 1'b0;
         sec_claim <= 1'b0;
         upstream_system_error_out <= 1'b0;
         downstream_parity_error_out <= 1'b0;
      end else begin
         apb_state <= next_apb_state;
         pready <= next_pready;
         pslverr <= next_pslverr;
         prdata <= next_prdata;
         bridge_control <= next_bridge_control;
         pri_command <= next_pri_command;
         sec_status <= next_sec_status;
         io_window <= next_io_window;
         mem_window <= next_mem_window;
         ma_target_abort <= next_ma_target_abort;
         ma_read_all_ones <= next_ma_read_all_ones;
         ma_write_discard <= next_ma_write_discard;
         ma_read_data <= next_ma_read_data;
         pri_claim_valid <= next_pri_claim_valid;
         pri_claim <= next_pri_claim;
         sec_claim_valid <= next_sec_claim_valid;
         sec_claim <= next_sec_claim;
         upstream_system_error_out <= next_upstream_system_error_out;
         downstream_parity_error_out <= next_downstream_parity_error_out;
      end
   end

   default clocking cb_main @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   property p_ctl_rsvd_zero;
      psel && penable && !pready && !pwrite &&
         (paddr == `PBDEC_OFS_BRCTL) |=> pready && !prdata[4];
   endproperty
   a_ctl_rsvd_zero: assert property (p_ctl_rsvd_zero)
      else $error("control bit 4 read back nonzero");

   property p_ctl_hold;
      wr_fire && (paddr == `PBDEC_OFS_BRCTL) |=>
         bridge_control == ($past(pwdata[15:0]) & 16'h002f);
   endproperty
   a_ctl_hold: assert property (p_ctl_hold)
      else $error("control write not stored");

   property p_ma_posted_serr;
      ma_event && master_abort_report_mode && ma_posted_done &&
         primary_syserr_enable |=> upstream_system_error_out &&
         !ma_target_abort;
   endproperty
   a_ma_posted_serr: assert property (p_ma_posted_serr)
      else $error("posted master abort not reported");

   property p_ma_delayed_abort;
      ma_event && master_abort_report_mode && !ma_posted_done |=>
         ma_target_abort ##1 !ma_target_abort;
   endproperty
   a_ma_delayed_abort: assert property (p_ma_delayed_abort)
      else $error("delayed master abort not target aborted");

   property p_ma_quiet;
      ma_event && !master_abort_report_mode && ma_read |=>
         ma_read_all_ones && (ma_read_data == 32'hffff_ffff) &&
         !ma_target_abort;
   endproperty
   a_ma_quiet: assert property (p_ma_quiet)
      else $error("silent abort did not return all ones");

   property upstream_system_error_out_fwd;
      serr_in_sync && secondary_error_forward_enable &&
         primary_syserr_enable |=> upstream_system_error_out;
   endproperty
   a_serr_fwd: assert property (upstream_system_error_out_fwd)
      else $error("downstream error not forwarded");

   property upstream_system_error_out_gate;
      !primary_syserr_enable |=> !upstream_system_error_out;
   endproperty
   a_serr_gate: assert property (upstream_system_error_out_gate)
      else $error("upstream error without primary enable");

   property p_perr_off;
      !secondary_parity_response_enable && !ma_event && !serr_in_sync
         |=> !downstream_parity_error_out && !upstream_system_error_out;
   endproperty
   a_perr_off: assert property (p_perr_off)
      else $error("parity reported while response disabled");

   property p_perr_on;
      sec_parity_err && secondary_parity_response_enable &&
         sec_parity_as_master |=> downstream_parity_error_out &&
         data_parity_detected_flag;
   endproperty
   a_perr_on: assert property (p_perr_on)
      else $error("parity error not signalled or flagged");

   property p_vid_mem_claim;
      pri_req_valid && !pri_req_io && legacy_video && memory_space_enable
         && (pri_req_addr >= 32'h000a_0000) &&
         (pri_req_addr <= 32'h000b_ffff) |=> pri_claim && pri_claim_valid;
   endproperty
   a_vid_mem_claim: assert property (p_vid_mem_claim)
      else $error("video memory access not claimed");

   property p_mem_enable;
      pri_req_valid && !pri_req_io && !memory_space_enable |=> !pri_claim;
   endproperty
   a_mem_enable: assert property (p_mem_enable)
      else $error("memory claimed with space disabled");

   c_posted_serr: cover property (ma_event && ma_posted_done &&
      master_abort_report_mode ##1 upstream_system_error_out);
   c_read_ones: cover property (ma_event ##1 ma_read_all_ones);
   c_vid_io: cover property (pri_req_valid && pri_req_io &&
      legacy_video ##1 pri_claim);
   c_parity: cover property (sec_parity_err ##1 data_parity_detected_flag);
endmodule : pbdec_ctrl

/* File: sim/pbdec_sec_agent.sv */
// Secondary-bus agent model: decode requests, parity errors, error pin
`timescale 1ns/100ps
module pbdec_sec_agent (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic req_go,
   input wire logic [31:0] req_addr,
   input wire logic req_io,
   input wire logic par_go,
   input wire logic serr_lvl,
   output logic sec_req_valid,
   output logic [31:0] sec_req_addr,
   output logic sec_req_io,
   output logic sec_parity_err,
   output logic sec_parity_as_master,
   output logic downstream_system_error_in
);
   initial sec_req_addr = 32'h0;
   initial sec_req_io = 1'h0;
   always @(posedge ref_clk) begin
      sec_req_valid <= req_go & ~sys_rst;
      // Idle bus shows inverted data so a stale value never looks valid
      sec_req_addr <= req_go ? req_addr : ~sec_req_addr;
      sec_req_io <= req_go ? req_io : ~sec_req_io;
      sec_parity_err <= par_go & ~sys_rst;
      sec_parity_as_master <= par_go;
      downstream_system_error_in <= serr_lvl;
   end
endmodule : pbdec_sec_agent

/* File: sim/pbdec_ctrl_tb.sv */
// Self-checking bench for the bridge decode and error control block
`timescale 1ns/100ps
module pbdec_ctrl_tb;
   logic ref_clk = '0, sys_rst = '1, psel = '0, penable = '0, pwrite = '0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = '0, pri_req_addr = '0, req_addr = '0, ta;
   logic ma_event = '0, ma_posted_done = '0, ma_read = '0, ti;
   logic pri_req_valid = '0, pri_req_io = '0, req_go = '0, req_io = '0;
   logic par_go = '0, serr_lvl = '0, ev_d = '0;
   logic [31:0] prdata, ma_read_data, sec_req_addr;
   logic pready, pslverr, ma_target_abort, ma_read_all_ones;
   logic ma_write_discard, pri_claim_valid, pri_claim, sec_req_valid;
   logic sec_req_io, sec_claim_valid, sec_claim, sec_parity_err;
   logic sec_parity_as_master, downstream_system_error_in;
   logic upstream_system_error_out, downstream_parity_error_out;
   logic [15:0] ctl = '0, cmd = '0;
   logic [1:0] ed;
   logic [4:0] ep, q_ev[$], q_pc[$], q_sc[$];
   logic [32:0] er, q_rd[$];
   logic [31:0] tbl[10] = '{32'h3b4, 32'h3cf, 32'h7b8, 32'h1080, 32'h1234,
      32'h2000, 32'h1_03b0, 32'ha_1000, 32'hb_8000, 32'hc_0000};
   int bad_count = 0, check_count = 0;
   wire [4:0] ev_seen = {ma_target_abort, ma_read_all_ones,
      ma_write_discard, upstream_system_error_out, downstream_parity_error_out};

   pbdec_ctrl pbdec_ctrl_inst (.*);
   pbdec_sec_agent pbdec_sec_agent_inst (.*);

   initial forever #2.5 ref_clk = ~ref_clk;

   task automatic end_of_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_of_test

   task automatic cmp_word(input string n, input logic [32:0] e, g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", n, e, g);
      end
   endtask : cmp_word

   task automatic cmp_flag(input string n, input logic [4:0] e, g);
      check_count++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %b seen %b", n, e, g);
      end
   endtask : cmp_flag

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [32:0] e);
      int n;
      if (!w) q_rd.push_back(e);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n == 50) begin
         bad_count++;
         end_of_test();
      end
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge ref_clk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'h1, a, d, 33'h0);
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      apb(1'h0, a, 32'h0, e);
   endtask : rd

   task automatic cfg(input logic [15:0] c, input logic [15:0] m);
      ctl = c;
      cmd = m;
      wr(8'h00, {16'h0, c});
      wr(8'h04, {16'h0, m});
   endtask : cfg

   // Expected {downstream claim, upstream forward} for one address
   function automatic logic [1:0] dec(input logic [31:0] a, input logic io);
      logic vio, vmem, inw, als;
      vio = ctl[3] && a[31:16] == 16'h0 &&
         ((a[9:0] >= 10'h3b0 && a[9:0] <= 10'h3bb) ||
          (a[9:0] >= 10'h3c0 && a[9:0] <= 10'h3df));
      vmem = ctl[3] && a >= 32'h000a_0000 && a <= 32'h000b_ffff;
      inw = io ? (a[31:16] == 16'h0 && a[15:0] >= 16'h0300 &&
         a[15:0] <= 16'h13ff) : a[31:16] == 16'h000a;
      als = ctl[2] && a[9:8] != 2'h0;
      if (io) dec = {cmd[0] & (vio | (inw & ~als)), ~vio & (~inw | als)};
      else dec = {cmd[1] & (vmem | inw), ~vmem & ~inw};
   endfunction : dec

   task automatic ev(input logic par, input logic p, input logic r);
      logic m;
      m = ctl[5];
      if (par) q_ev.push_back({3'h0, cmd[8] & ctl[0], ctl[0]});
      else q_ev.push_back({m & ~p, ~m & r, ~m & ~r, m & p & cmd[8], 1'h0});
      par_go <= par;
      ma_event <= ~par;
      ma_posted_done <= p;
      ma_read <= r;
      @(posedge ref_clk);
      par_go <= 1'h0;
      ma_event <= 1'h0;
      repeat (3) @(posedge ref_clk);
   endtask : ev

   // Each result that appears takes the oldest note of its kind
   always @(posedge ref_clk) begin
      ev_d <= ma_event | sec_parity_err;
      if (pri_claim_valid === 1'b1) begin
         ep = q_pc.pop_front();
         cmp_flag("pri", ep, {4'h0, pri_claim});
      end
      if (sec_claim_valid === 1'b1) begin
         ep = q_sc.pop_front();
         cmp_flag("sec", ep, {4'h0, sec_claim});
      end
      if (ev_d === 1'b1) begin
         ep = q_ev.pop_front();
         cmp_flag("events", ep, ev_seen);
      end
      if (psel & penable & ~pwrite & (pready === 1'b1)) begin
         er = q_rd.pop_front();
         cmp_word("prdata", er, {pslverr, prdata});
      end
   end

   initial begin
      void'($urandom(32'hf4123112));
      repeat (20) @(posedge ref_clk);
      sys_rst <= 1'h0;
      @(posedge ref_clk);
      rd(8'h00, 33'h0);
      rd(8'h04, 33'h0);
      rd(8'h08, 33'h0);
      wr(8'h00, 32'hffff_ffff);
      rd(8'h00, 33'h2f);
      rd(8'h18, 33'h1_0000_0000);
      $display("test registers done");
      wr(8'h0c, 32'h13ff_0300);
      wr(8'h10, 32'h000a_000a);
      // decode in every video, alias and enable setting
      for (int k = 0; k < 16; k++) begin
         cfg({12'h0, k[1:0], 2'h0}, {14'h0, k[3:2]});
         repeat (12) begin
            ta = tbl[$urandom % 10] ^ ($urandom & 32'h3);
            ti = 1'($urandom);
            ed = dec(ta, ti);
            q_pc.push_back({4'h0, ed[1]});
            q_sc.push_back({4'h0, ed[0]});
            pri_req_valid <= 1'h1;
            pri_req_addr <= ta;
            pri_req_io <= ti;
            req_go <= 1'h1;
            req_addr <= ta;
            req_io <= ti;
            @(posedge ref_clk);
         end
         pri_req_valid <= 1'h0;
         req_go <= 1'h0;
         @(posedge ref_clk);
      end
      $display("test decode done");
      // every abort mode, qualifier and enable
      for (int k = 0; k < 16; k++) begin
         cfg({10'h0, k[0], 5'h0}, {7'h0, k[1], 8'h0});
         ev(1'h0, k[2], k[3]);
      end
      $display("test master abort done");
      for (int k = 0; k < 2; k++) begin
         cfg({15'h0, k[0]}, 16'h0100);
         ev(1'h1, 1'h0, 1'h0);
         rd(8'h08, {24'h0, k[0], 8'h0});
         wr(8'h08, 32'h0000_0100);
      end
      $display("test parity done");
      // error pin forwarding under both enables
      for (int k = 0; k < 4; k++) begin
         cfg({14'h0, k[0], 1'h0}, {7'h0, k[1], 8'h0});
         serr_lvl <= 1'h1;
         repeat (6) @(posedge ref_clk);
         rd(8'h14, {32'h1, k[0] & k[1]});
         serr_lvl <= 1'h0;
         repeat (6) @(posedge ref_clk);
      end
      $display("test error forward done");
      repeat (5) @(posedge ref_clk);
      if (q_rd.size() + q_ev.size() + q_pc.size() + q_sc.size() != 0)
         bad_count++;
      end_of_test();
   end

   initial begin
      repeat (100000) @(posedge ref_clk);
      bad_count++;
      end_of_test();
   end
endmodule : pbdec_ctrl_tb
